// file: hw/adc_map.vh
// Register map, field positions and reset values of the converter control
`ifndef ADC_MAP_VH
`define ADC_MAP_VH

// Register offsets (byte addresses on the 2-bit register port)
`define ADC_STATUS_CONTROL_OFS 2'h0
`define ADC_RESULT_HIGH_OFS 2'h1
`define ADC_RESULT_LOW_OFS 2'h2
`define ADC_CLOCK_CONFIG_OFS 2'h3

// Status and control fields
`define CONV_DONE_FLAG_BIT 7
`define CONV_IRQ_ENABLE_BIT 6
`define CONTINUOUS_CONV_BIT 5
`define CHANNEL_SELECT_MSB 4
`define CHANNEL_SELECT_LSB 0
`define CHANNEL_SELECT_RESET 5'h1f

// Channel codes
`define CH_LAST_EXTERNAL 5'h07
`define CH_REF_HIGH 5'h1d
`define CH_REF_LOW 5'h1e
`define CH_POWER_OFF 5'h1f

// Clock configuration fields
`define CLOCK_PRESCALE_MSB 7
`define CLOCK_PRESCALE_LSB 5
`define CLOCK_SOURCE_SEL_BIT 4
`define FORMAT_SEL_HI_BIT 3
`define FORMAT_SEL_LO_BIT 2
`define CLOCK_PRESCALE_RESET 3'h0
`define CLOCK_SOURCE_SEL_RESET 1'b0
`define FORMAT_SEL_RESET 2'h1

// Result formats
`define FMT_TRUNC 2'h0
`define FMT_RIGHT 2'h1
`define FMT_LEFT 2'h2
`define FMT_LEFT_SIGNED 2'h3

// Conversion timing in converter clock cycles, and the first SAR trial code
`define CONV_LAST_STEP 5'h10
`define SAR_LAST_STEP 5'h0a
`define SAR_FIRST_TRIAL 10'h200

`endif

// file: hw/adc_clk_div.v
// Converter clock prescaler: turns source ticks into converter ticks
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.vh"

module adc_clk_div (
  input wire clk,
  input wire rstn,
  input wire src_tick,
  input wire [2:0] clock_prescale,
  input wire restart,
  output wire adc_tick
);

  reg [3:0] cnt_q;
  reg [3:0] cnt_d;

  // Last count of a divide period for each prescale code
  function [3:0] div_limit;
    input [2:0] code;
    begin
      case (code)
        3'h0: div_limit = 4'h0;
        3'h1: div_limit = 4'h1;
        3'h2: div_limit = 4'h3;
        3'h3: div_limit = 4'h7;
        default: div_limit = 4'hf;
      endcase
    end
  endfunction

  // One converter tick per full divide period
  assign adc_tick = src_tick && (cnt_q >= div_limit(clock_prescale)); // [R21]

  // Period counter, realigned on each restart
  always @* begin
    cnt_d = cnt_q;
    if (restart) begin
      cnt_d = 4'h0;
    end else if (adc_tick) begin
      cnt_d = 4'h0;
    end else if (src_tick) begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // adc_clk_div

`default_nettype wire

// file: hw/adc_sequencer_result_regs.v
// Converter sequencer, control registers and result formatting
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.vh"

// Behaviour
// [R1] Enabled interrupt raised at every conversion end
// [R2] Result read or control write drops interrupt
// [R3] Polled mode: done flag until result read
// [R4] Interrupt mode: done flag never set, reads zero
// [R5] Software writes zero into done-flag bit
// [R6] Continuous repeats; otherwise one per write
// [R7] Five-bit channel code, inputs 0 to 7
// [R8] Reference codes for self-check; others undefined
// [R9] All-ones channel code powers converter off
// [R10] Software waits one conversion after power-up
// [R11] Wait mode: keep converting, interrupt wakes
// [R12] Stop mode aborts; resumes after exit
// [R13] Software discards first conversion after stop
// [R14] Left format: eight high, two low bits
// [R15] Right format: two high, eight low bits
// [R16] Signed left format inverts result MSB
// [R17] High read freezes low; new results dropped
// [R18] Truncation: low holds upper eight, no interlock
// [R19] Format codes; reset selects right-justified
// [R20] Write starts conversion of 16-17 clocks
// [R21] Prescale divides by 1,2,4,8 or 16
// [R22] Clock source bit: bus or oscillator
// [R23] Left formats put low bits on top
// [R24] Control write restarts running conversion
module adc_sequencer_result_regs (
  input wire clk,
  input wire rstn,
  input wire [1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire oscillator_clock,
  input wire stop_mode,
  input wire cmp_in,
  output wire [4:0] analog_sel,
  output wire conv_power_on,
  output wire sample_en,
  output wire [9:0] sar_trial,
  output wire conv_irq
);

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_CONV = 3'b010;
  localparam [2:0] S_STOP = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [4:0] step_q;
  reg [4:0] step_d;
  reg [9:0] trial_q;
  reg [9:0] trial_d;
  reg [9:0] result_q;
  reg go_q;
  reg go_d;
  reg conv_irq_enable_q;
  reg continuous_conv_q;
  reg [4:0] channel_select_q;
  reg [2:0] clock_prescale_q;
  reg clock_source_sel_q;
  reg [1:0] format_q;
  reg conv_done_flag_q;
  reg irq_q;
  reg hold_q;
  reg osc_meta_q;
  reg osc_sync_q;
  reg osc_prev_q;
  reg [7:0] rdata_d;

  wire ctrl_wr;
  wire clk_wr;
  wire rd_high;
  wire rd_low;
  wire result_rd;
  wire powered;
  wire src_tick;
  wire adc_tick;
  wire restart;
  wire conv_end;
  wire store_ok;

  // Bit weight of the trial for a given step
  function [9:0] sar_mask;
    input [4:0] step;
    begin
      sar_mask = `SAR_FIRST_TRIAL >> (step - 5'h1);
    end
  endfunction

  // High result byte in each format
  function [7:0] fmt_high;
    input [1:0] fmt;
    input [9:0] r;
    begin
      case (fmt)
        `FMT_TRUNC: fmt_high = 8'h00; // [R18]
        `FMT_RIGHT: fmt_high = {6'h00, r[9:8]}; // [R15]
        `FMT_LEFT: fmt_high = r[9:2]; // [R14]
        default: fmt_high = {~r[9], r[8:2]}; // [R16]
      endcase
    end
  endfunction

  // Low result byte in each format
  function [7:0] fmt_low;
    input [1:0] fmt;
    input [9:0] r;
    begin
      case (fmt)
        `FMT_TRUNC: fmt_low = r[9:2]; // [R18]
        `FMT_RIGHT: fmt_low = r[7:0]; // [R15]
        default: fmt_low = {r[1:0], 6'h00}; // [R14] [R23]
      endcase
    end
  endfunction

  // Register port decode
  assign ctrl_wr = wr && (addr == `ADC_STATUS_CONTROL_OFS);
  assign clk_wr = wr && (addr == `ADC_CLOCK_CONFIG_OFS);
  assign rd_high = rd && (addr == `ADC_RESULT_HIGH_OFS);
  assign rd_low = rd && (addr == `ADC_RESULT_LOW_OFS);
  assign result_rd = rd_high || rd_low;

  // Converter powered unless all-ones channel code
  assign powered = (channel_select_q != `CH_POWER_OFF); // [R9]
  assign conv_power_on = powered && (state_q != S_STOP); // [R9] [R12]
  assign analog_sel = channel_select_q; // [R7] [R8]
  assign sample_en = (state_q == S_CONV) && (step_q == 5'h00);
  assign sar_trial = trial_q;
  assign conv_irq = irq_q; // [R11]

  // Oscillator pin synchroniser and rising edge detect
  always @(posedge clk) begin
    if (!rstn) begin
      osc_meta_q <= 1'b0;
      osc_sync_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      osc_meta_q <= oscillator_clock;
      osc_sync_q <= osc_meta_q;
      osc_prev_q <= osc_sync_q;
    end
  end

  // Prescaler input: bus clock or oscillator edges
  assign src_tick = clock_source_sel_q ? 1'b1 : // [R22]
                    (osc_sync_q && !osc_prev_q);
  assign restart = ctrl_wr || (state_q != S_CONV);

  adc_clk_div u_div (
    .clk(clk),
    .rstn(rstn),
    .src_tick(src_tick),
    .clock_prescale(clock_prescale_q),
    .restart(restart),
    .adc_tick(adc_tick)
  );

  assign conv_end = (state_q == S_CONV) && adc_tick &&
                    (step_q == `CONV_LAST_STEP); // [R20]
  assign store_ok = !(hold_q && (format_q != `FMT_TRUNC)); // [R17]

  // Conversion sequencer
  always @* begin
    state_d = state_q;
    step_d = step_q;
    trial_d = trial_q;
    go_d = go_q;
    case (state_q)
      S_IDLE: begin
        if (go_q && powered) begin
          state_d = S_CONV;
          step_d = 5'h00;
          trial_d = 10'h000;
        end
      end
      S_CONV: begin
        if (!powered) begin
          state_d = S_IDLE; // [R9]
        end else if (adc_tick) begin
          step_d = step_q + 5'h01;
          if (step_q == 5'h00) begin
            trial_d = `SAR_FIRST_TRIAL;
          end else if (step_q <= `SAR_LAST_STEP) begin
            // Keep the bit if the comparator says input is higher
            if (!cmp_in) begin
              trial_d = trial_q & ~sar_mask(step_q);
            end
            if (step_q < `SAR_LAST_STEP) begin
              trial_d = trial_d | sar_mask(step_q + 5'h01);
            end
          end
          if (step_q == `CONV_LAST_STEP) begin
            step_d = 5'h00;
            go_d = continuous_conv_q; // [R6]
            if (!continuous_conv_q) begin
              state_d = S_IDLE;
            end else begin
              trial_d = 10'h000;
            end
          end
        end
      end
      S_STOP: begin
        if (!stop_mode) begin
          state_d = S_IDLE; // [R12]
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    // A control write (re)starts a conversion from the first step
    if (ctrl_wr) begin
      go_d = 1'b1; // [R6] [R20]
      step_d = 5'h00; // [R24]
      trial_d = 10'h000; // [R24]
      state_d = S_IDLE;
    end
    // Stop mode aborts whatever runs, keeping the request pending
    if (stop_mode) begin
      state_d = S_STOP; // [R12]
      step_d = 5'h00;
      trial_d = 10'h000;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      step_q <= 5'h00;
      trial_q <= 10'h000;
      go_q <= 1'b0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      trial_q <= trial_d;
      go_q <= go_d;
    end
  end

  // Control registers; done-flag write bit ignored
  always @(posedge clk) begin
    if (!rstn) begin
      conv_irq_enable_q <= 1'b0; // [R1]
      continuous_conv_q <= 1'b0; // [R6]
      channel_select_q <= `CHANNEL_SELECT_RESET;
      clock_prescale_q <= `CLOCK_PRESCALE_RESET;
      clock_source_sel_q <= `CLOCK_SOURCE_SEL_RESET; // [R22]
      format_q <= `FORMAT_SEL_RESET; // [R19]
    end else begin
      if (ctrl_wr) begin
        conv_irq_enable_q <= wdata[`CONV_IRQ_ENABLE_BIT];
        continuous_conv_q <= wdata[`CONTINUOUS_CONV_BIT];
        channel_select_q <=
          wdata[`CHANNEL_SELECT_MSB:`CHANNEL_SELECT_LSB]; // [R7]
      end
      if (clk_wr) begin
        clock_prescale_q <=
          wdata[`CLOCK_PRESCALE_MSB:`CLOCK_PRESCALE_LSB]; // [R21]
        clock_source_sel_q <= wdata[`CLOCK_SOURCE_SEL_BIT];
        format_q <= {wdata[`FORMAT_SEL_HI_BIT],
                     wdata[`FORMAT_SEL_LO_BIT]}; // [R19]
      end
    end
  end

  // Result store, skipped while the high/low interlock holds
  always @(posedge clk) begin
    if (!rstn) begin
      result_q <= 10'h000;
    end else if (conv_end && store_ok) begin
      result_q <= trial_q; // [R6] [R17]
    end
  end

  // In the justified formats a high read freezes the result until the low read
  always @(posedge clk) begin
    if (!rstn) begin
      hold_q <= 1'b0;
    end else if (rd_low || (format_q == `FMT_TRUNC)) begin
      hold_q <= 1'b0; // [R18]
    end else if (rd_high) begin
      hold_q <= 1'b1; // [R17]
    end
  end

  // Done flag and interrupt: a completing conversion beats a clear
  always @(posedge clk) begin
    if (!rstn) begin
      conv_done_flag_q <= 1'b0; // [R3]
      irq_q <= 1'b0;
    end else begin
      if (conv_end && !conv_irq_enable_q) begin
        conv_done_flag_q <= 1'b1; // [R3]
      end else if (result_rd || conv_irq_enable_q) begin
        conv_done_flag_q <= 1'b0; // [R3] [R4]
      end
      if (conv_end && conv_irq_enable_q) begin
        irq_q <= 1'b1; // [R1]
      end else if (result_rd || ctrl_wr || !conv_irq_enable_q) begin
        irq_q <= 1'b0; // [R2]
      end
    end
  end

  // Read mux; data stand in the cycle after the strobe
  always @* begin
    rdata_d = 8'h00;
    if (rd) begin
      case (addr)
        `ADC_STATUS_CONTROL_OFS: begin
          rdata_d = {conv_done_flag_q && !conv_irq_enable_q, // [R4]
                     conv_irq_enable_q, continuous_conv_q,
                     channel_select_q};
        end
        `ADC_RESULT_HIGH_OFS: rdata_d = fmt_high(format_q, result_q);
        `ADC_RESULT_LOW_OFS: rdata_d = fmt_low(format_q, result_q);
        `ADC_CLOCK_CONFIG_OFS: begin
          rdata_d = {clock_prescale_q, clock_source_sel_q, format_q,
                     2'h0};
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_d;
    end
  end

endmodule // adc_sequencer_result_regs

`default_nettype wire

// file: testbench/adc_ctrl_monitor.sv
// Assertion checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_monitor (
  input wire clk,
  input wire rstn,
  input wire [1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire stop_mode,
  input wire [4:0] analog_sel,
  input wire conv_power_on,
  input wire sample_en,
  input wire [9:0] sar_trial,
  input wire conv_irq
);
  logic en_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Tracks the interrupt enable bit as software wrote it
  always @(posedge clk) begin
    if (!rstn)
      en_q <= 1'b0;
    else if (wr && addr == 2'h0)
      en_q <= wdata[6];
  end
  sequence s_ctl_wr;
    wr && addr == 2'h0;
  endsequence
  // Sample step left by a converter tick, not by a write or a stop
  sequence s_sample_end;
    sample_en && !wr && !stop_mode ##1 !sample_en && conv_power_on;
  endsequence
  AST_CH_SEL: assert property (
    s_ctl_wr |=> analog_sel == $past(wdata[4:0]))
    else $error("channel select not applied");
  AST_START: assert property (
    wr && addr == 2'h0 && wdata[4:0] != 5'h1f && !stop_mode
    |-> ##[1:4] sample_en) else $error("conversion did not start");
  AST_TRIAL: assert property (
    s_sample_end |-> sar_trial == 10'h200)
    else $error("first trial code wrong");
  AST_POLL_ONLY: assert property (
    rd && addr == 2'h0 ##1 rdata[6] |-> !rdata[7])
    else $error("done flag set with interrupt enabled");
  AST_WR_CLR: assert property (
    s_ctl_wr |=> !conv_irq) else $error("interrupt kept after write");
  AST_PWR_OFF: assert property (
    analog_sel == 5'h1f |-> !conv_power_on && !sample_en)
    else $error("converter on with off code");
  AST_STOP: assert property (
    stop_mode [*3] |-> !conv_power_on && !sample_en)
    else $error("converter active in stop");
  AST_IRQ_EN: assert property (
    $rose(conv_irq) |-> en_q) else $error("interrupt while disabled");
endmodule // adc_ctrl_monitor
bind adc_sequencer_result_regs adc_ctrl_monitor u_mon (.clk(clk),
  .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .stop_mode(stop_mode), .analog_sel(analog_sel),
  .conv_power_on(conv_power_on), .sample_en(sample_en),
  .sar_trial(sar_trial), .conv_irq(conv_irq));
`default_nettype wire

// file: testbench/test_adc_sequencer_result_regs.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module test_adc_sequencer_result_regs;
  logic clk, rstn, wr, rd, osc, stop_mode, conv_power_on, sample_en, conv_irq;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [9:0] vin, sar_trial;
  logic [4:0] analog_sel;
  logic [2:0] osc_cnt;
  int miscompares, num_checks;
  // Ideal comparator on the trial code
  wire cmp_in = (vin >= sar_trial);
  adc_sequencer_result_regs dut (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .oscillator_clock(osc), .stop_mode(stop_mode), .cmp_in(cmp_in),
    .analog_sel(analog_sel), .conv_power_on(conv_power_on),
    .sample_en(sample_en), .sar_trial(sar_trial), .conv_irq(conv_irq));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Oscillator pin at one eighth of the clock
  always @(posedge clk) begin
    osc_cnt <= osc_cnt + 3'h1;
    osc <= osc_cnt[2];
  end
  task automatic stop_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [1:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Polls the done flag, or the interrupt line, under a bound
  task automatic wait_done(input bit irq);
    int n;
    d = 8'h00;
    for (n = 0; n < 600 && d[7] !== 1'b1; n++) begin
      if (irq) begin
        @(posedge clk);
        #1 d[7] = conv_irq;
      end else
        rreg(2'h0);
    end
    if (d[7] !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t ns: conversion never ended", $time);
      stop_test();
    end
  endtask
  function automatic logic [15:0] fmt_exp(input logic [1:0] f,
                                          input logic [9:0] r);
    case (f)
      2'h0: return {8'h00, r[9:2]};
      2'h1: return {6'h00, r};
      2'h2: return {r, 6'h00};
      default: return {~r[9], r[8:0], 6'h00};
    endcase
  endfunction
  task automatic chk_res(input logic [1:0] f, input logic [9:0] r);
    logic [7:0] h;
    rreg(2'h1);
    h = d;
    rreg(2'h2);
    check({h, d}, fmt_exp(f, r));
  endtask
  task automatic t_reset;
    rreg(2'h0);
    check(d, 8'h1f);
    rreg(2'h3);
    check(d, 8'h04);
    check(conv_power_on, 1'b0);
  endtask
  task automatic t_single;
    logic [2:0] f;
    vin = 10'h2c5;
    wreg(2'h3, 8'h14);
    // First conversion after power-up is thrown away
    wreg(2'h0, 8'h03);
    wait_done(1'b0);
    rreg(2'h2);
    wreg(2'h0, 8'h03);
    check(analog_sel, 5'h03);
    wait_done(1'b0);
    // Format is applied at read time, so one result serves all four
    for (f = 0; f < 4; f++) begin
      wreg(2'h3, {4'h1, f[1:0], 2'h0});
      chk_res(f[1:0], vin);
    end
    rreg(2'h0);
    check(d[7], 1'b0);
    repeat (60) @(posedge clk);
    rreg(2'h0);
    check(d[7], 1'b0);
  endtask
  task automatic t_lock;
    wreg(2'h3, 8'h14);
    vin = 10'h155;
    wreg(2'h0, 8'h03);
    wait_done(1'b0);
    rreg(2'h1);
    vin = 10'h3aa;
    wreg(2'h0, 8'h03);
    repeat (40) @(posedge clk);
    rreg(2'h2);
    check(d, 8'h55);
    chk_res(2'h1, 10'h155);
    wreg(2'h3, 8'h10);
    wreg(2'h0, 8'h03);
    wait_done(1'b0);
    rreg(2'h1);
    check(d, 8'h00);
    vin = 10'h0f0;
    wreg(2'h0, 8'h03);
    wait_done(1'b0);
    rreg(2'h2);
    check(d, 8'h3c);
  endtask
  task automatic t_irq;
    wreg(2'h0, 8'h43);
    wait_done(1'b1);
    rreg(2'h0);
    check(d, 8'h43);
    check(conv_irq, 1'b1);
    wreg(2'h0, 8'h43);
    check(conv_irq, 1'b0);
    wait_done(1'b1);
    rreg(2'h2);
    check(conv_irq, 1'b0);
  endtask
  task automatic t_cont;
    wreg(2'h3, 8'h14);
    vin = 10'h101;
    wreg(2'h0, 8'h23);
    wait_done(1'b0);
    // Top bits agree with the old input, as the next cycle may be underway
    vin = 10'h1fe;
    chk_res(2'h1, 10'h101);
    wait_done(1'b0);
    chk_res(2'h1, 10'h1fe);
    wait_done(1'b0);
    chk_res(2'h1, 10'h1fe);
    wreg(2'h0, 8'h1f);
  endtask
  task automatic t_stop;
    wreg(2'h0, 8'h03);
    repeat (5) @(posedge clk);
    stop_mode <= 1'b1;
    repeat (60) @(posedge clk);
    #1 check(conv_power_on, 1'b0);
    rreg(2'h0);
    check(d[7], 1'b0);
    @(posedge clk);
    stop_mode <= 1'b0;
    wait_done(1'b0);
    // First result after stop is discarded, then a fresh one is judged
    rreg(2'h2);
    wreg(2'h0, 8'h03);
    wait_done(1'b0);
    chk_res(2'h1, vin);
  endtask
  // Conversion length for bus div 1, bus div 16 and oscillator div 1
  task automatic t_time;
    logic [7:0] cfg [3] = '{8'h14, 8'h94, 8'h04};
    int m [3] = '{1, 16, 8};
    int i, t0, cyc;
    for (i = 0; i < 3; i++) begin
      wreg(2'h3, cfg[i]);
      wreg(2'h0, 8'h03);
      t0 = $time;
      wait_done(1'b0);
      cyc = ($time - t0) / 4;
      check(cyc >= 16 * m[i] && cyc <= 18 * m[i] + 8, 1'b1);
      rreg(2'h2);
    end
  endtask
  initial begin
    {rstn, wr, rd, stop_mode, osc} = 5'h00;
    addr = 2'h0;
    wdata = 8'h00;
    vin = 10'h000;
    osc_cnt = 3'h0;
    miscompares = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_single();
    t_lock();
    t_irq();
    t_cont();
    t_stop();
    t_time();
    stop_test();
  end
endmodule // test_adc_sequencer_result_regs
`default_nettype wire
